// >>> src/svd_detector.sv
// Purpose: APB-controlled low supply detector with delayed request flag
// Assumes: comparator runs asynchronously to pclk
// Notes: flag delay is a parameter so simulation can shorten it
//
// Local design decisions: the register addresses and the APB slave port.
module svd_detector
#(
	parameter int FLAG_DLY = svd_pkg::FLAG_DLY_CYC
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clk_en,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                sleep_mode,
	input  wire logic                idle_mode,
	input  wire logic                cmp_low_async,
	output svd_pkg::svd_cfg_t        analog_cfg,
	output logic                     mf_irq_req,
	output logic                     idle_wake,
	output logic                     irq
);
	import svd_pkg::*;

	logic [2:0]  sel_q;
	logic        en_q;
	logic        out_q;
	logic        flag_q;
	logic        ien_q;
	logic        gie_q;
	logic [1:0]  stat_q;
	logic [1:0]  mask_q;
	logic        s1_q;
	logic        s2_q;
	logic        flag_prev_q;
	logic [31:0] cnt_q;
	logic [31:0] low_run_q;
	logic [31:0] prdata_q;
	svd_state_t  st_q;
	logic        active;
	logic        wr;
	logic        rd;
	logic        flag_set;
	logic        out_rise;
	logic        flag_rise;
	logic        hit;

	assign active = en_q & ~sleep_mode;
	assign analog_cfg.en = active;
	assign analog_cfg.sel = sel_q;
	assign wr = psel & penable & pwrite & clk_en;
	assign rd = psel & penable & ~pwrite & clk_en;
	assign pready = 1'b1;
	assign hit = (paddr == SVD_CTRL_OFS) | (paddr == SVD_MFI_OFS)
		| (paddr == SVD_STAT_OFS) | (paddr == SVD_MASK_OFS);
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_q;

	// Comparator synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else if (clk_en) begin
			s1_q <= cmp_low_async;
			s2_q <= s1_q;
		end
	end

	// Output flag follows the synchronised comparator while active
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
		end else if (clk_en) begin
			out_q <= active & s2_q;
		end
	end

	assign out_rise = active & s2_q & ~out_q;

	// Delay from output rising to request flag; a drop restarts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= SVD_IDLE;
			cnt_q <= 32'h0;
		end else if (clk_en) begin
			case (st_q)
				SVD_IDLE: begin
					cnt_q <= 32'h0;
					if (out_rise)
						st_q <= SVD_WAIT;
				end
				SVD_WAIT: begin
					if (!out_q) begin
						cnt_q <= 32'h0;
						if (!out_rise)
							st_q <= SVD_IDLE;
					end else if (cnt_q >= 32'(FLAG_DLY - 1)) begin
						st_q <= SVD_HELD;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				SVD_HELD: begin
					if (!out_q) begin
						cnt_q <= 32'h0;
						if (out_rise)
							st_q <= SVD_WAIT;
						else
							st_q <= SVD_IDLE;
					end
				end
				default: st_q <= SVD_IDLE;
			endcase
		end
	end

	assign flag_set = (st_q == SVD_WAIT) & out_q
		& (cnt_q >= 32'(FLAG_DLY - 1));

	// Consecutive cycles of high output flag, for the delay check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_run_q <= 32'h0;
		else if (clk_en && out_q)
			low_run_q <= low_run_q + 32'h1;
		else if (clk_en)
			low_run_q <= 32'h0;
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= 3'h0;
			en_q <= 1'b0;
		end else if (wr && paddr == SVD_CTRL_OFS && pstrb[0]) begin
			sel_q <= pwdata[2:0];
			en_q <= pwdata[CTRL_EN_BIT];
		end
	end

	// Multi-function register; hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
			ien_q <= 1'b0;
			gie_q <= 1'b0;
		end else if (clk_en) begin
			if (wr && paddr == SVD_MFI_OFS && pstrb[0]) begin
				flag_q <= pwdata[MFI_FLAG_BIT] | flag_set;
				ien_q <= pwdata[MFI_EN_BIT];
				gie_q <= pwdata[GIE_BIT];
			end else if (flag_set) begin
				flag_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_prev_q <= 1'b0;
		else if (clk_en)
			flag_prev_q <= flag_q;
	end

	assign flag_rise = flag_q & ~flag_prev_q;
	assign mf_irq_req = flag_q & ien_q;
	assign idle_wake = idle_mode & flag_set & ~flag_q & clk_en;

	// Sticky event status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= EV_RESET;
			mask_q <= EV_RESET;
		end else if (clk_en) begin
			if (wr && paddr == SVD_MASK_OFS && pstrb[0])
				mask_q <= pwdata[1:0];
			for (int i = 0; i < 2; i++) begin
				if ((i == EV_LOW_BIT && out_rise)
						|| (i == EV_FLAG_BIT && flag_rise))
					stat_q[i] <= 1'b1;
				else if (wr && paddr == SVD_STAT_OFS && pstrb[0]
						&& pwdata[i])
					stat_q[i] <= 1'b0;
			end
		end
	end

	assign irq = gie_q & (mf_irq_req | |(stat_q & mask_q));

	// Read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				SVD_CTRL_OFS: prdata_q <= {26'h0, out_q, en_q,
					1'b0, sel_q};
				SVD_MFI_OFS: prdata_q <= {24'h0, gie_q, 2'h0,
					flag_q, 3'h0, ien_q};
				SVD_STAT_OFS: prdata_q <= {30'h0, stat_q};
				SVD_MASK_OFS: prdata_q <= {30'h0, mask_q};
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	sequence s_steady_low;
		out_q [*8];
	endsequence

	property p_flag_delay;
		@(posedge pclk) disable iff (!presetn)
		$rose(flag_q) && !$past(wr && paddr == SVD_MFI_OFS)
			|-> $past(out_q) && $past(low_run_q) >= 32'(FLAG_DLY - 1);
	endproperty
	a_flag_delay: assert property (p_flag_delay)
		else $error("request flag set without low output");

	property p_sleep_off;
		@(posedge pclk) disable iff (!presetn)
		sleep_mode |-> !analog_cfg.en;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("detector active in sleep");

	property p_en_power;
		@(posedge pclk) disable iff (!presetn)
		analog_cfg.en |-> en_q;
	endproperty
	a_en_power: assert property (p_en_power)
		else $error("detector powered while disabled");

	property p_out_off;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !active |=> !out_q;
	endproperty
	a_out_off: assert property (p_out_off)
		else $error("output flag high while inactive");

	property p_irq_gate;
		@(posedge pclk) disable iff (!presetn)
		!gie_q |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt with global enable clear");

	property p_mf_req;
		@(posedge pclk) disable iff (!presetn)
		mf_irq_req |-> flag_q && ien_q;
	endproperty
	a_mf_req: assert property (p_mf_req)
		else $error("shared request without flag and enable");

	property p_ctrl_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == SVD_CTRL_OFS
			|=> prdata[7:6] == 2'h0 && !prdata[3];
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("unimplemented control bits read nonzero");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		idle_wake |=> flag_q;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake without request flag");

	property p_sync;
		@(posedge pclk) disable iff (!presetn)
		clk_en && active && $past(clk_en) |=> out_q == $past(s2_q);
	endproperty
	a_sync: assert property (p_sync)
		else $error("output not from second sync stage");

	property p_steady;
		@(posedge pclk) disable iff (!presetn)
		s_steady_low |-> st_q != SVD_IDLE || !clk_en;
	endproperty
	a_steady: assert property (p_steady)
		else $error("delay not running during steady low");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		flag_q && !(wr && paddr == SVD_MFI_OFS) |=> flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("request flag lost without software write");

	property p_ctrl_write;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == SVD_CTRL_OFS && pstrb[0]
			|=> en_q == $past(pwdata[CTRL_EN_BIT])
			&& sel_q == $past(pwdata[2:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write did not land");

	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(out_q) && $stable(flag_q) && $stable(st_q)
			&& $stable(cnt_q) && $stable(en_q);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	property p_irq_on;
		@(posedge pclk) disable iff (!presetn)
		gie_q && flag_q && ien_q |-> irq && mf_irq_req;
	endproperty
	a_irq_on: assert property (p_irq_on)
		else $error("enabled request without interrupt");

	sequence s_hw_set_idle;
		clk_en && idle_mode && !flag_q
			&& !(wr && paddr == SVD_MFI_OFS) ##1 flag_q;
	endsequence

	property p_wake_all;
		@(posedge pclk) disable iff (!presetn)
		s_hw_set_idle |-> $past(idle_wake);
	endproperty
	a_wake_all: assert property (p_wake_all)
		else $error("flag set in idle without wake");
endmodule

// >>> src/svd_pkg.sv
// Purpose: constants and types for the supply low-voltage detector
// Assumes: APB slave, 32-bit data, 25 MHz pclk
// Notes: offsets of the four registers are local choices
package svd_pkg;
	localparam logic [11:0] SVD_CTRL_OFS = 12'h000;
	localparam logic [11:0] SVD_MFI_OFS  = 12'h004;
	localparam logic [11:0] SVD_STAT_OFS = 12'h008;
	localparam logic [11:0] SVD_MASK_OFS = 12'h00C;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_EN_BIT  = 4;
	localparam int MFI_FLAG_BIT = 4;
	localparam int MFI_EN_BIT   = 0;
	localparam int GIE_BIT      = 7;
	localparam int EV_LOW_BIT   = 0;
	localparam int EV_FLAG_BIT  = 1;
	localparam int CLK_MHZ      = 25;
	localparam int FLAG_DLY_US  = 120;
	localparam int FLAG_DLY_CYC = FLAG_DLY_US * CLK_MHZ;
	localparam logic [1:0] EV_RESET = 2'h0;

	typedef struct packed {
		logic [2:0] sel;
		logic       en;
	} svd_cfg_t;

	typedef enum logic [1:0] {
		SVD_IDLE,
		SVD_WAIT,
		SVD_HELD
	} svd_state_t;
endpackage

// >>> tb/tb.sv
// Purpose: self-checking bench for the supply low-voltage detector
// Assumes: zero-wait APB slave, short flag delay of 8 cycles
// Notes: clk_en is dropped once to check that state freezes
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import svd_pkg::*;
	localparam int DLY = 8;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        sleep_mode = 0, idle_mode = 0, cmp_low_async = 0;
	logic        clk_en = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, mf_irq_req, idle_wake, irq, err, woke;
	svd_cfg_t    analog_cfg;
	int          fails = 0, total_checks = 0, n;
	always #20 pclk = ~pclk;
	svd_detector #(.FLAG_DLY(DLY)) dut (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.idle_mode(idle_mode), .cmp_low_async(cmp_low_async),
		.analog_cfg(analog_cfg), .mf_irq_req(mf_irq_req),
		.idle_wake(idle_wake), .irq(irq));
	task stop_test;
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			fails++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task t_reset;
		rdc(SVD_CTRL_OFS, 32'h0);
		rdc(SVD_MFI_OFS, 32'h0);
		rdc(SVD_STAT_OFS, 32'h0);
		rdc(SVD_MASK_OFS, 32'h0);
		chk(irq, 1'b0);
		$display("Test reset done");
	endtask
	task t_ctrl;
		for (int i = 0; i < 8; i++) begin
			wr(SVD_CTRL_OFS, 32'hFFFF_FFF8 | i);
			rdc(SVD_CTRL_OFS, 32'h10 | i);
			chk({analog_cfg.sel, analog_cfg.en}, {i[2:0], 1'b1});
		end
		sleep_mode <= 1;
		@(negedge pclk);
		chk(analog_cfg.en, 1'b0);
		@(posedge pclk);
		sleep_mode <= 0;
		wr(SVD_CTRL_OFS, 32'h0);
		chk(analog_cfg.en, 1'b0);
		apb(1'b1, 12'h010, 32'hFF);
		chk(err, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("Test control done");
	endtask
	task t_freeze;
		clk_en <= 0;
		wr(SVD_CTRL_OFS, 32'h17);
		chk({analog_cfg.sel, analog_cfg.en}, 4'h0);
		clk_en <= 1;
		rdc(SVD_CTRL_OFS, 32'h0);
		wr(SVD_CTRL_OFS, 32'h17);
		chk({analog_cfg.sel, analog_cfg.en}, 4'hF);
		$display("Test freeze done");
	endtask
	task t_low;
		wr(SVD_CTRL_OFS, 32'h10);
		wr(SVD_MFI_OFS, 32'h01);
		idle_mode <= 1;
		cmp_low_async <= 1;
		repeat (6) @(posedge pclk);
		cmp_low_async <= 0;
		repeat (4) @(posedge pclk);
		chk(mf_irq_req, 1'b0);
		cmp_low_async <= 1;
		n = 0;
		woke = 0;
		do begin
			@(negedge pclk);
			n++;
			woke |= idle_wake;
		end while (mf_irq_req !== 1'b1 && n < 40);
		if (mf_irq_req !== 1'b1) begin
			fails++;
			stop_test();
		end
		@(posedge pclk);
		chk(n >= DLY + 3 && n <= DLY + 8, 1'b1);
		chk(woke, 1'b1);
		chk(irq, 1'b0);
		rdc(SVD_CTRL_OFS, 32'h30);
		wr(SVD_MFI_OFS, 32'h91);
		chk(irq, 1'b1);
		rdc(SVD_STAT_OFS, 32'h3);
		wr(SVD_MFI_OFS, 32'h80);
		rdc(SVD_MFI_OFS, 32'h80);
		chk(irq, 1'b0);
		wr(SVD_MASK_OFS, 32'h2);
		chk(irq, 1'b1);
		wr(SVD_STAT_OFS, 32'h3);
		chk(irq, 1'b0);
		rdc(SVD_STAT_OFS, 32'h0);
		cmp_low_async <= 0;
		idle_mode <= 0;
		$display("Test low supply done");
	endtask
	task t_preset;
		wr(SVD_MFI_OFS, 32'h10);
		rdc(SVD_MFI_OFS, 32'h10);
		idle_mode <= 1;
		cmp_low_async <= 1;
		woke = 0;
		repeat (24) begin
			@(negedge pclk);
			woke |= idle_wake;
		end
		chk(woke, 1'b0);
		$display("Test preset flag done");
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset();
		t_ctrl();
		t_freeze();
		t_low();
		t_preset();
		stop_test();
	end
endmodule
